// ===== rtl/sdb_pkg.sv
package sdb_pkg;
	// Address layout
	localparam int ADDR_W = 12; // A11..A0
	localparam int BANK_BIT = 11; // Bank select line
	localparam int AP_BIT = 10; // Auto-precharge / all-banks line
	localparam int COL_W = 8; // Column bits kept, A8 and A9 dropped
	// Mode load spacing, in cycles
	localparam int MODE_GAP_CYC = 2;
	// Self-refresh exit time, in cycles
	localparam int SR_EXIT_CYC = 4;
	// Command code packs cs_n, ras_n, cas_n, we_n
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_BST = 4'h6;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_MODE = 4'h0;
	localparam logic [3:0] CMD_DESELECT_CMD = 4'hF;

	// Per-bank state
	typedef enum logic [2:0] {
		SDB_IDLE = 3'h0,
		SDB_ACTIVE = 3'h1,
		SDB_READ = 3'h2,
		SDB_WRITE = 3'h3,
		SDB_RDAP = 3'h4,
		SDB_WRAP = 3'h5
	} sdb_bank_t;

	// Device power/clock state
	typedef enum logic [2:0] {
		SDB_RUN = 3'h0,
		SDB_SELF = 3'h1,
		SDB_SRREC = 3'h2,
		SDB_PDOWN = 3'h3,
		SDB_SUSP = 3'h4
	} sdb_pwr_t;
endpackage

// ===== rtl/sdb_if.sv
`timescale 1ns/1ps
interface sdb_if;
	logic cke; // Clock enable
	logic cs_n; // Chip select, low active
	logic ras_n; // Row strobe, low active
	logic cas_n; // Column strobe, low active
	logic we_n; // Write enable, low active
	logic [sdb_pkg::ADDR_W-1:0] addr; // A11..A0

	// Controller side drives the command pins
	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, addr);
	// Device side samples them
	modport dev (input cke, cs_n, ras_n, cas_n, we_n, addr);
endinterface

// ===== rtl/sdb_dev.sv
`timescale 1ns/1ps
// How it works
// - Rising clock enable wakes self-refresh, power-down
// - Self-refresh exit by deselect/no-op, then idle
// - Recovery plus enable fall enters power-down
// - Enable low-then-high leaves power-down to idle
// - Idle banks decode nop, act, refresh, mode
// - Idle enable fall: self-refresh or power-down
// - Controller holds refresh with enable low only if enable already low and banks busy
// - Elsewhere enable fall suspends clock next cycle
// - Controller gives defined command at suspend
// - Decisions use previous and current enable
// - Read moves selected bank to read
// - Write moves selected bank to write
// - Activate idles bank to row active
// - Column address ignores A8 and A9
// - Precharge idles one or both banks
// - Refresh, mode need idle; stop returns active
// - Controller waits two cycles after mode
module sdb_dev (
	input wire logic mclk, // 200 MHz clock
	input wire logic sys_rst, // Async reset, high
	sdb_if.dev bus, // Command pins from controller
	output sdb_pkg::sdb_bank_t bank0_st, // Bank 0 state
	output sdb_pkg::sdb_bank_t bank1_st, // Bank 1 state
	output sdb_pkg::sdb_pwr_t pwr_st, // Power state
	output logic [sdb_pkg::COL_W-1:0] col_addr, // Latched column
	output logic illegal_pulse // Illegal command seen
);
	// Banks and power state
	sdb_pkg::sdb_bank_t bank_ff [2];
	sdb_pkg::sdb_bank_t nxt_bank [2];
	sdb_pkg::sdb_pwr_t pwr_ff, nxt_pwr;
	logic cke_prev_ff; // Enable at previous edge
	logic [2:0] srx_cnt_ff, nxt_srx_cnt; // Exit timer
	logic [sdb_pkg::COL_W-1:0] col_ff, nxt_col;
	logic ill_ff, nxt_ill;
	logic [3:0] cmd; // Packed command pins
	logic bsel, ap, all_idle;

	// Recovery/exit encodings: deselect or no-op class
	function automatic logic nop_class(input logic [3:0] c);
		return c[3] | (c[2] & c[1]);
	endfunction

	// Bank that may take a column access
	function automatic logic can_access(input sdb_pkg::sdb_bank_t b);
		return b == sdb_pkg::SDB_ACTIVE || b == sdb_pkg::SDB_READ ||
			b == sdb_pkg::SDB_WRITE;
	endfunction

	assign cmd = bus.cs_n ? sdb_pkg::CMD_DESELECT_CMD :
		{1'b0, bus.ras_n, bus.cas_n, bus.we_n};
	assign bsel = bus.addr[sdb_pkg::BANK_BIT];
	assign ap = bus.addr[sdb_pkg::AP_BIT];
	assign all_idle = bank_ff[0] == sdb_pkg::SDB_IDLE &&
		bank_ff[1] == sdb_pkg::SDB_IDLE;

	// Next state of power mode and banks
	always_comb begin
		nxt_bank = bank_ff;
		nxt_pwr = pwr_ff;
		nxt_srx_cnt = srx_cnt_ff;
		nxt_col = col_ff;
		nxt_ill = 1'b0;
		case (pwr_ff)
			sdb_pkg::SDB_SELF: begin
				// Wake on enable rise, checked against last edge
				if (!cke_prev_ff && bus.cke) begin
					if (nop_class(cmd)) begin
						nxt_pwr = sdb_pkg::SDB_SRREC;
						nxt_srx_cnt = 3'(sdb_pkg::SR_EXIT_CYC);
					end else begin
						nxt_ill = 1'b1;
					end
				end
			end
			sdb_pkg::SDB_SRREC: begin
				// Wait exit time, or drop into power-down
				if (!nop_class(cmd)) begin
					nxt_ill = 1'b1;
				end else if (cke_prev_ff && !bus.cke) begin
					nxt_pwr = sdb_pkg::SDB_PDOWN;
				end else if (srx_cnt_ff <= 3'h1) begin
					nxt_pwr = sdb_pkg::SDB_RUN;
					nxt_srx_cnt = 3'h0;
				end else begin
					nxt_srx_cnt = srx_cnt_ff - 3'h1;
				end
			end
			sdb_pkg::SDB_PDOWN: begin
				// Leave on low-then-high enable
				if (!cke_prev_ff && bus.cke) begin
					nxt_pwr = sdb_pkg::SDB_RUN;
				end
			end
			sdb_pkg::SDB_SUSP: begin
				// Suspension ends on enable rise
				if (!cke_prev_ff && bus.cke) begin
					nxt_pwr = sdb_pkg::SDB_RUN;
				end
			end
			default: begin
				if (all_idle && !cke_prev_ff) begin
					nxt_pwr = sdb_pkg::SDB_PDOWN;
				end else if (all_idle && !bus.cke && cmd == sdb_pkg::CMD_REF) begin
					nxt_pwr = sdb_pkg::SDB_SELF;
				end else if (!all_idle && !bus.cke) begin
					// Busy banks with enable low suspend the clock
					nxt_pwr = sdb_pkg::SDB_SUSP;
				end
				// Commands taken only when enable was high at the previous edge
				if (cke_prev_ff) begin
					case (cmd)
						sdb_pkg::CMD_BST: begin
							for (int i = 0; i < 2; i++) begin
								if (can_access(bank_ff[i])) begin
									nxt_bank[i] = sdb_pkg::SDB_ACTIVE;
								end
							end
						end
						sdb_pkg::CMD_READ, sdb_pkg::CMD_WRITE: begin
							if (can_access(bank_ff[bsel])) begin
								if (cmd == sdb_pkg::CMD_READ) begin
									nxt_bank[bsel] = ap ? sdb_pkg::SDB_RDAP :
										sdb_pkg::SDB_READ;
								end else begin
									nxt_bank[bsel] = ap ? sdb_pkg::SDB_WRAP :
										sdb_pkg::SDB_WRITE;
								end
								nxt_col = bus.addr[sdb_pkg::COL_W-1:0];
							end else begin
								nxt_ill = 1'b1;
							end
						end
						sdb_pkg::CMD_ACT: begin
							if (bank_ff[bsel] == sdb_pkg::SDB_IDLE) begin
								nxt_bank[bsel] = sdb_pkg::SDB_ACTIVE;
							end else begin
								nxt_ill = 1'b1;
							end
						end
						sdb_pkg::CMD_PRE: begin
							if (ap) begin
								nxt_bank[0] = sdb_pkg::SDB_IDLE;
								nxt_bank[1] = sdb_pkg::SDB_IDLE;
							end else begin
								nxt_bank[bsel] = sdb_pkg::SDB_IDLE;
							end
						end
						sdb_pkg::CMD_REF, sdb_pkg::CMD_MODE: begin
							if (!all_idle) begin
								nxt_ill = 1'b1;
							end
						end
						default: begin
							// Deselect and no-op keep state
						end
					endcase
				end
			end
		endcase
	end

	// Register stage
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bank_ff[0] <= sdb_pkg::SDB_IDLE;
			bank_ff[1] <= sdb_pkg::SDB_IDLE;
			pwr_ff <= sdb_pkg::SDB_RUN;
			cke_prev_ff <= 1'b1;
			srx_cnt_ff <= 3'h0;
			col_ff <= 8'h00;
			ill_ff <= 1'b0;
		end else begin
			bank_ff <= nxt_bank;
			pwr_ff <= nxt_pwr;
			cke_prev_ff <= bus.cke;
			srx_cnt_ff <= nxt_srx_cnt;
			col_ff <= nxt_col;
			ill_ff <= nxt_ill;
		end
	end

	assign bank0_st = bank_ff[0];
	assign bank1_st = bank_ff[1];
	assign pwr_st = pwr_ff;
	assign col_addr = col_ff;
	assign illegal_pulse = ill_ff;
endmodule

// ===== rtl/sdb_ctrl.sv
`timescale 1ns/1ps
// Controller end: one request at a time, paced for the device
module sdb_ctrl (
	input wire logic mclk, // 200 MHz clock
	input wire logic sys_rst, // Async reset, high
	sdb_if.ctrl bus, // Command pins to device
	input wire logic req_valid, // Command request
	input wire logic [3:0] req_cmd, // Packed cs,ras,cas,we
	input wire logic [sdb_pkg::ADDR_W-1:0] req_addr, // Address
	input wire logic req_cke, // Wanted clock enable level
	input wire logic banks_idle, // User asserts both banks idle
	output logic req_ready // Request may be taken
);
	logic [3:0] cmd_ff, nxt_cmd;
	logic [sdb_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
	logic cke_ff, nxt_cke;
	logic [1:0] gap_ff, nxt_gap; // Wait after mode load
	logic cke_ok;

	// Refresh with enable low held only if enable is already low and banks busy; others pass
	assign cke_ok = req_cke | banks_idle | cke_ff |
		(req_cmd != sdb_pkg::CMD_REF);
	assign req_ready = gap_ff == 2'h0;

	// Next pin values
	always_comb begin
		nxt_cmd = sdb_pkg::CMD_NOP;
		nxt_addr = addr_ff;
		nxt_cke = cke_ff;
		nxt_gap = (gap_ff != 2'h0) ? gap_ff - 2'h1 : 2'h0;
		if (req_valid && req_ready && cke_ok) begin
			nxt_cmd = req_cmd;
			nxt_addr = req_addr;
			nxt_cke = req_cke;
			if (req_cmd == sdb_pkg::CMD_MODE) begin
				nxt_gap = 2'(sdb_pkg::MODE_GAP_CYC);
			end
		end
	end

	// Pin registers
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_ff <= sdb_pkg::CMD_NOP;
			addr_ff <= 12'h000;
			cke_ff <= 1'b1;
			gap_ff <= 2'h0;
		end else begin
			cmd_ff <= nxt_cmd;
			addr_ff <= nxt_addr;
			cke_ff <= nxt_cke;
			gap_ff <= nxt_gap;
		end
	end

	assign bus.cke = cke_ff;
	assign bus.cs_n = cmd_ff[3];
	assign bus.ras_n = cmd_ff[2];
	assign bus.cas_n = cmd_ff[1];
	assign bus.we_n = cmd_ff[0];
	assign bus.addr = addr_ff;
endmodule

// ===== verification/sdb_chk.sv
`timescale 1ns/1ps
// Pin and state relations; bank 0 idle 1 active 4 read-ap
// Power 0 run 1 self 2 recovery 3 down 4 suspend
module sdb_chk (
	input logic mclk, // Clock
	input logic sys_rst, // Reset
	input logic cke, // Clock enable
	input logic cs_n, // Select
	input logic ras_n, // Row strobe
	input logic cas_n, // Column strobe
	input logic we_n, // Write
	input logic [sdb_pkg::ADDR_W-1:0] addr, // Address
	input sdb_pkg::sdb_bank_t bank0_st, // Bank 0
	input sdb_pkg::sdb_bank_t bank1_st, // Bank 1
	input sdb_pkg::sdb_pwr_t pwr_st, // Power state
	input logic illegal_pulse // Flag
);
	wire [3:0] c = {cs_n, ras_n, cas_n, we_n}; // Packed command
	wire idl = bank0_st == 3'h0 && bank1_st == 3'h0; // Both idle
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Command cycle that the device obeys
	sequence s_on;
		pwr_st == 3'h0 && cke && $past(cke);
	endsequence
	a_mode_gap: assert property (c == 4'h0 |=> (c == 4'h7)[*2])
		else $error("mode load not followed by two idle cycles");
	a_act_bank: assert property (s_on ##0 (c == 4'h3 && !addr[11] &&
		bank0_st == 3'h0) |=> bank0_st == 3'h1 && $stable(bank1_st))
		else $error("activate did not open bank 0");
	a_read_ap: assert property (s_on ##0 (c == 4'h5 && !addr[11] &&
		addr[10] && bank0_st == 3'h1) |=> bank0_st == 3'h4)
		else $error("read with precharge missed");
	a_pre_all: assert property (s_on ##0 (c == 4'h2 && addr[10]) |=> idl)
		else $error("precharge all left a bank open");
	a_self_entry: assert property (pwr_st == 3'h0 && idl && $past(cke) &&
		!cke && c == 4'h1 |=> pwr_st == 3'h1)
		else $error("self-refresh not entered");
	a_sr_wake: assert property (pwr_st == 3'h1 && !$past(cke) && cke &&
		(c[3] || c[2:1] == 2'h3) |=> pwr_st == 3'h2)
		else $error("self-refresh wake missed");
	a_pd_exit: assert property (pwr_st == 3'h3 && !$past(cke) && cke
		|=> pwr_st == 3'h0)
		else $error("power-down exit missed");
	a_clk_susp: assert property (pwr_st == 3'h0 && !idl && $past(cke) &&
		!cke |=> pwr_st == 3'h4)
		else $error("clock suspend missed");
	a_ref_busy: assert property (s_on ##0 (c == 4'h1 && !idl)
		|=> illegal_pulse)
		else $error("refresh with open bank not flagged");
	a_pd_entry: assert property (pwr_st == 3'h0 && idl && !$past(cke)
		|=> pwr_st == 3'h3)
		else $error("power-down not entered");
	a_rec_pdown: assert property (pwr_st == 3'h2 && $past(cke) && !cke &&
		(c[3] || c[2:1] == 2'h3) |=> pwr_st == 3'h3)
		else $error("recovery did not drop to power-down");
endmodule

// ===== verification/test_sdram_cke_bank_state_logic.sv
`timescale 1ns/1ps
// Drives the controller user side, checks the device end
module test_sdram_cke_bank_state_logic;
	logic mclk = 1'b0; // Clock
	logic sys_rst = 1'b1; // Reset
	logic req_valid = 1'b0; // Request
	logic [3:0] req_cmd = 4'h7; // Command
	logic [sdb_pkg::ADDR_W-1:0] req_addr = 12'h000; // Address
	logic req_cke = 1'b1; // Wanted enable
	logic banks_idle = 1'b1; // Idle hint
	logic req_ready; // Ready
	sdb_pkg::sdb_bank_t bank0_st, bank1_st; // Bank states
	sdb_pkg::sdb_pwr_t pwr_st; // Power state
	logic [7:0] col_addr; // Column
	logic illegal_pulse; // Flag
	int err_total = 0; // Mismatches
	int n_checks = 0; // Comparisons
	int n_ill = 0; // Illegal flags seen
	sdb_if sdb_if_inst ();
	sdb_ctrl sdb_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst), .bus(sdb_if_inst),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
		.req_cke(req_cke), .banks_idle(banks_idle), .req_ready(req_ready));
	sdb_dev sdb_dev_inst (.mclk(mclk), .sys_rst(sys_rst), .bus(sdb_if_inst),
		.bank0_st(bank0_st), .bank1_st(bank1_st), .pwr_st(pwr_st),
		.col_addr(col_addr), .illegal_pulse(illegal_pulse));
	sdb_chk sdb_chk_inst (.mclk(mclk), .sys_rst(sys_rst),
		.cke(sdb_if_inst.cke), .cs_n(sdb_if_inst.cs_n),
		.ras_n(sdb_if_inst.ras_n), .cas_n(sdb_if_inst.cas_n),
		.we_n(sdb_if_inst.we_n), .addr(sdb_if_inst.addr),
		.bank0_st(bank0_st), .bank1_st(bank1_st), .pwr_st(pwr_st),
		.illegal_pulse(illegal_pulse));
	// 200 MHz clock
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	// Idle hint follows the bank states
	always @(negedge mclk) begin
		banks_idle <= bank0_st == 3'h0 && bank1_st == 3'h0;
	end
	// Count illegal-command flags
	always @(posedge mclk) begin
		if (illegal_pulse === 1'b1) begin
			n_ill <= n_ill + 1;
		end
	end
	// Compare and count
	task chk(input string s, input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	// Present a request and hold it until taken
	task send(input logic [3:0] c, input logic [11:0] a, input logic k);
		int w;
		@(negedge mclk);
		req_valid = 1'b1;
		req_cmd = c;
		req_addr = a;
		req_cke = k;
		w = 0;
		while (req_ready !== 1'b1 && w < 20) begin
			@(negedge mclk);
			w++;
		end
		@(posedge mclk);
	endtask
	// Release and let states settle
	task sl(input int n);
		@(negedge mclk);
		req_valid = 1'b0;
		repeat (n) @(negedge mclk);
	endtask
	// Both banks and power state
	task ex(input logic [2:0] b0, input logic [2:0] b1, input logic [2:0] p);
		chk("bank0", {5'h00, bank0_st}, {5'h00, b0});
		chk("bank1", {5'h00, bank1_st}, {5'h00, b1});
		chk("power", {5'h00, pwr_st}, {5'h00, p});
	endtask
	// One command then its states
	task op(input logic [3:0] c, input logic [11:0] a, input logic k,
		input logic [2:0] b0, input logic [2:0] b1, input logic [2:0] p);
		send(c, a, k);
		sl(3);
		ex(b0, b1, p);
	endtask
	// Verdict and end of run
	task final_report;
		if (err_total == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Hang guard, far beyond the sequence length
	initial begin
		#20000;
		err_total++;
		final_report;
	end
	// Command sequence
	initial begin
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		sys_rst = 1'b0;
		ex(3'h0, 3'h0, 3'h0);
		op(4'h3, 12'h000, 1'h1, 3'h1, 3'h0, 3'h0);
		op(4'h3, 12'h800, 1'h1, 3'h1, 3'h1, 3'h0);
		op(4'h4, 12'hB05, 1'h1, 3'h1, 3'h3, 3'h0);
		chk("column", col_addr, 8'h05);
		op(4'h6, 12'h000, 1'h1, 3'h1, 3'h1, 3'h0);
		op(4'h5, 12'h7FF, 1'h1, 3'h4, 3'h1, 3'h0);
		chk("column", col_addr, 8'hFF);
		op(4'h1, 12'h000, 1'h1, 3'h4, 3'h1, 3'h0);
		chk("illegal", 8'(n_ill), 8'h01);
		op(4'h7, 12'h000, 1'h0, 3'h4, 3'h1, 3'h4);
		op(4'h7, 12'h000, 1'h1, 3'h4, 3'h1, 3'h0);
		op(4'h2, 12'h800, 1'h1, 3'h4, 3'h0, 3'h0);
		op(4'h2, 12'h400, 1'h1, 3'h0, 3'h0, 3'h0);
		send(4'h0, 12'h020, 1'h1);
		op(4'h3, 12'h000, 1'h1, 3'h1, 3'h0, 3'h0);
		op(4'h2, 12'h400, 1'h1, 3'h0, 3'h0, 3'h0);
		op(4'h1, 12'h000, 1'h1, 3'h0, 3'h0, 3'h0);
		op(4'h1, 12'h000, 1'h0, 3'h0, 3'h0, 3'h1);
		send(4'h7, 12'h000, 1'h1);
		sl(10);
		ex(3'h0, 3'h0, 3'h0);
		op(4'h1, 12'h000, 1'h0, 3'h0, 3'h0, 3'h1);
		send(4'h7, 12'h000, 1'h1);
		send(4'h7, 12'h000, 1'h0);
		sl(3);
		ex(3'h0, 3'h0, 3'h3);
		op(4'h7, 12'h000, 1'h1, 3'h0, 3'h0, 3'h0);
		op(4'hF, 12'h000, 1'h0, 3'h0, 3'h0, 3'h3);
		op(4'h7, 12'h000, 1'h1, 3'h0, 3'h0, 3'h0);
		chk("illegal", 8'(n_ill), 8'h01);
		final_report;
	end
endmodule
